// [design/usb_endpoint_config_regs.sv]
`timescale 1ns/1ps
module usb_endpoint_config_regs
   import usb_cfg_pkg::*;
#(
   parameter int endpoints = endpoint_count
) (
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic [addr_width-1:0] s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [addr_width-1:0] s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   input  wire logic                  host_mode,
   input  wire logic                  chip_idle,
   input  wire logic                  chip_sleep,
   input  wire logic                  line_driving,
   input  wire logic [3:0]            token_endpoint,
   input  wire logic                  token_setup,
   input  wire logic                  stall_event,
   output logic [31:0]                table_base,
   output logic                       eye_pattern_test_en,
   output logic                       drive_enable_monitor,
   output logic                       module_run,
   output logic                       module_suspended,
   output logic                       clk48_enable,
   output logic                       low_speed_direct,
   output logic                       use_preamble,
   output logic                       hw_nak_retry,
   output logic                       token_rx_allowed,
   output logic                       token_tx_allowed,
   output logic                       token_setup_allowed,
   output logic                       token_handshake,
   output logic                       irq
);
   typedef enum logic [2:0] {
      run_state     = 3'b001,
      halted_state  = 3'b010,
      suspend_state = 3'b100
   } power_state_type;

   logic [7:0]            table_ptr_low_bits, next_table_ptr_low_bits;
   logic [7:0]            table_ptr_mid_byte, next_table_ptr_mid_byte;
   logic [7:0]            table_ptr_top_byte, next_table_ptr_top_byte;
   logic [7:0]            usb_module_config, next_usb_module_config;
   logic [7:0]            power_control_reg, next_power_control_reg;
   logic [7:0]            irq_status, next_irq_status;
   logic [7:0]            irq_mask, next_irq_mask;
   logic [7:0]            endpoint_control [endpoints];
   logic [7:0]            next_endpoint_control [endpoints];
   power_state_type       power_state, next_power_state;
   logic                  wr_strobe, rd_strobe, wr_ok, rd_ok;
   logic [addr_width-1:0] wr_addr, rd_addr;
   logic [7:0]            wr_byte, rd_byte;
   logic                  idle_level, sleep_level, drive_level;
   logic                  suspend_want, halt_want;
   logic [7:0]            irq_events;
   logic                  stall_hit;
   logic                  was_suspended;

   function automatic logic addr_is_endpoint(input logic [addr_width-1:0] a);
      return a[1:0] == 2'b00 && a >= endpoint_base
         && a < endpoint_base + 8'(endpoints * 4);
   endfunction : addr_is_endpoint

   function automatic logic [3:0] endpoint_index(input logic [addr_width-1:0] a);
      return 4'((a - endpoint_base) >> 2);
   endfunction : endpoint_index

   function automatic logic addr_is_mapped(input logic [addr_width-1:0] a);
      return addr_is_endpoint(a) || a == ptr_low_off || a == ptr_mid_off
         || a == ptr_top_off || a == module_cfg_off || a == power_ctrl_off
         || a == irq_status_off || a == irq_mask_off || a == state_off;
   endfunction : addr_is_mapped

   usb_cfg_axi_slave bus (
      .clk           (clk),
      .rst           (rst),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .wr_strobe     (wr_strobe),
      .wr_addr       (wr_addr),
      .wr_byte       (wr_byte),
      .wr_ok         (wr_ok),
      .rd_strobe     (rd_strobe),
      .rd_addr       (rd_addr),
      .rd_byte       (rd_byte),
      .rd_ok         (rd_ok)
   );

   usb_pin_sync #(
      .width (3)
   ) pins (
      .clk   (clk),
      .rst   (rst),
      .pin   ({chip_idle, chip_sleep, line_driving}),
      .level ({idle_level, sleep_level, drive_level})
   );

   assign wr_ok = addr_is_mapped(wr_addr);
   assign rd_ok = addr_is_mapped(rd_addr);
   assign stall_hit = stall_event;
   assign was_suspended = power_state == suspend_state;
   assign suspend_want  = (usb_module_config[auto_suspend_bit] && sleep_level)
                          || power_control_reg[manual_suspend_bit];
   assign halt_want     = usb_module_config[stop_idle_bit] && idle_level;

   // read mux: upper 24 bits are zero-filled by the slave
   always_comb
   begin
      rd_byte = 8'h00;
      if (addr_is_endpoint(rd_addr))
         rd_byte = endpoint_control[endpoint_index(rd_addr)];
      else
         case (rd_addr)
            ptr_low_off:    rd_byte = table_ptr_low_bits;
            ptr_mid_off:    rd_byte = table_ptr_mid_byte;
            ptr_top_off:    rd_byte = table_ptr_top_byte;
            module_cfg_off: rd_byte = usb_module_config;
            power_ctrl_off: rd_byte = power_control_reg;
            irq_status_off: rd_byte = irq_status;
            irq_mask_off:   rd_byte = irq_mask;
            state_off:      rd_byte = {5'b00000, power_state};
            default:        rd_byte = 8'h00;
         endcase
   end

   always_comb
   begin
      next_table_ptr_low_bits = table_ptr_low_bits;
      next_table_ptr_mid_byte = table_ptr_mid_byte;
      next_table_ptr_top_byte = table_ptr_top_byte;
      next_usb_module_config  = usb_module_config;
      next_power_control_reg  = power_control_reg;
      next_irq_mask           = irq_mask;
      next_irq_status         = irq_status;
      next_endpoint_control   = endpoint_control;
      irq_events              = 8'h00;
      if (wr_strobe)
      begin
         if (addr_is_endpoint(wr_addr))
            next_endpoint_control[endpoint_index(wr_addr)] = wr_byte & endpoint_mask;
         else
            case (wr_addr)
               ptr_low_off:    next_table_ptr_low_bits = wr_byte & ptr_low_mask;
               ptr_mid_off:    next_table_ptr_mid_byte = wr_byte;
               ptr_top_off:    next_table_ptr_top_byte = wr_byte;
               module_cfg_off: next_usb_module_config  = wr_byte & module_cfg_mask;
               power_ctrl_off: next_power_control_reg  = wr_byte & power_ctrl_mask;
               irq_mask_off:   next_irq_mask           = wr_byte & irq_mask_bits;
               irq_status_off: next_irq_status         = irq_status & ~wr_byte;
               default:        ;
            endcase
      end
      // stall status set by hardware wins over a software write
      if (stall_hit)
         next_endpoint_control[token_endpoint][stall_bit] = 1'b1;
      irq_events[irq_stall_bit]   = stall_hit;
      irq_events[irq_suspend_bit] = next_power_state == suspend_state && !was_suspended;
      next_irq_status = next_irq_status | irq_events;
   end

   always_comb
   begin
      next_power_state = power_state;
      // suspend outranks the idle halt in every state
      case (power_state)
         run_state:
            if (suspend_want)
               next_power_state = suspend_state;
            else if (halt_want)
               next_power_state = halted_state;
         halted_state:
            if (suspend_want)
               next_power_state = suspend_state;
            else if (!halt_want)
               next_power_state = run_state;
         suspend_state:
            if (!suspend_want)
               next_power_state = run_state;
         default:
            next_power_state = run_state;
      endcase
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         table_ptr_low_bits   <= reg_reset;
         table_ptr_mid_byte   <= reg_reset;
         table_ptr_top_byte   <= reg_reset;
         usb_module_config    <= reg_reset;
         power_control_reg    <= reg_reset;
         irq_status           <= reg_reset;
         irq_mask             <= reg_reset;
         power_state          <= run_state;
         for (int i = 0; i < endpoints; i++)
            endpoint_control[i] <= reg_reset;
         table_base           <= 32'h00000000;
         eye_pattern_test_en  <= 1'b0;
         drive_enable_monitor <= 1'b0;
         module_run           <= 1'b1;
         module_suspended     <= 1'b0;
         clk48_enable         <= 1'b1;
         low_speed_direct     <= 1'b0;
         use_preamble         <= 1'b0;
         hw_nak_retry         <= 1'b0;
         token_rx_allowed     <= 1'b0;
         token_tx_allowed     <= 1'b0;
         token_setup_allowed  <= 1'b0;
         token_handshake      <= 1'b0;
         irq                  <= 1'b0;
      end
      else
      begin
         table_ptr_low_bits   <= next_table_ptr_low_bits;
         table_ptr_mid_byte   <= next_table_ptr_mid_byte;
         table_ptr_top_byte   <= next_table_ptr_top_byte;
         usb_module_config    <= next_usb_module_config;
         power_control_reg    <= next_power_control_reg;
         irq_status           <= next_irq_status;
         irq_mask             <= next_irq_mask;
         power_state          <= next_power_state;
         endpoint_control     <= next_endpoint_control;
         table_base           <= {next_table_ptr_top_byte, next_table_ptr_mid_byte,
                                  next_table_ptr_low_bits[7:1], 9'h000};
         eye_pattern_test_en  <= next_usb_module_config[eye_test_bit];
         drive_enable_monitor <= usb_module_config[oe_monitor_bit] && drive_level;
         module_run           <= next_power_state == run_state;
         module_suspended     <= next_power_state == suspend_state;
         clk48_enable         <= next_power_state != suspend_state;
         low_speed_direct     <= host_mode && next_endpoint_control[0][low_speed_bit];
         use_preamble         <= host_mode && !next_endpoint_control[0][low_speed_bit];
         hw_nak_retry         <= host_mode && !next_endpoint_control[0][retry_dis_bit];
         token_rx_allowed     <= endpoint_control[token_endpoint][rx_en_bit];
         token_tx_allowed     <= endpoint_control[token_endpoint][tx_en_bit];
         token_setup_allowed  <= token_setup && endpoint_control[token_endpoint][rx_en_bit]
                                 && endpoint_control[token_endpoint][tx_en_bit]
                                 && !endpoint_control[token_endpoint][ctrl_dis_bit];
         token_handshake      <= endpoint_control[token_endpoint][handshake_bit];
         irq                  <= (next_irq_status & irq_mask) != 8'h00;
      end
   end

   a_upper_zero: assert property (@(posedge clk) disable iff (rst)
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("upper read bits not zero");
   a_base_align: assert property (@(posedge clk) disable iff (rst)
      table_base[8:0] == 9'h000 && table_base[31:24] == table_ptr_top_byte)
      else $error("table base misformed");
   a_base_mid: assert property (@(posedge clk) disable iff (rst)
      table_base[23:9] == {table_ptr_mid_byte, table_ptr_low_bits[7:1]})
      else $error("table base middle bits wrong");
   a_eye_follow: assert property (@(posedge clk) disable iff (rst)
      eye_pattern_test_en == usb_module_config[eye_test_bit])
      else $error("eye test enable mismatch");
   a_oe_monitor: assert property (@(posedge clk) disable iff (rst)
      !usb_module_config[oe_monitor_bit] |=> !drive_enable_monitor)
      else $error("oe indication active while disabled");
   a_idle_stop: assert property (@(posedge clk) disable iff (rst)
      usb_module_config[stop_idle_bit] && idle_level && power_state == run_state
      && !power_control_reg[manual_suspend_bit] && !sleep_level |=> !module_run)
      else $error("module kept running in idle");
   a_auto_susp: assert property (@(posedge clk) disable iff (rst)
      usb_module_config[auto_suspend_bit] && sleep_level |=> module_suspended)
      else $error("no automatic suspend on sleep");
   a_clk_gate: assert property (@(posedge clk) disable iff (rst)
      power_control_reg[manual_suspend_bit] |=> !clk48_enable ##0 module_suspended)
      else $error("manual suspend did not gate clock");
   a_retry_off: assert property (@(posedge clk) disable iff (rst)
      endpoint_control[0][retry_dis_bit] |-> !hw_nak_retry)
      else $error("nak retry while disabled");
   a_rx_gate: assert property (@(posedge clk) disable iff (rst)
      !endpoint_control[token_endpoint][rx_en_bit] |=> !token_rx_allowed)
      else $error("receive allowed while disabled");
   a_stall_set: assert property (@(posedge clk) disable iff (rst)
      stall_hit |=> endpoint_control[$past(token_endpoint)][stall_bit])
      else $error("stall status not set");
   a_low_speed: assert property (@(posedge clk) disable iff (rst)
      low_speed_direct |-> endpoint_control[0][low_speed_bit] && !use_preamble)
      else $error("low-speed direct without enable");
   a_tx_gate: assert property (@(posedge clk) disable iff (rst)
      !endpoint_control[token_endpoint][tx_en_bit] |=> !token_tx_allowed)
      else $error("transmit allowed while disabled");
   a_setup_gate: assert property (@(posedge clk) disable iff (rst)
      endpoint_control[token_endpoint][ctrl_dis_bit] |=> !token_setup_allowed)
      else $error("setup allowed on data-only endpoint");
   a_handshake_gate: assert property (@(posedge clk) disable iff (rst)
      !endpoint_control[token_endpoint][handshake_bit] |=> !token_handshake)
      else $error("handshake while disabled");
   a_manual_only: assert property (@(posedge clk) disable iff (rst)
      !usb_module_config[auto_suspend_bit] && !power_control_reg[manual_suspend_bit]
      |=> !module_suspended)
      else $error("suspended without request");
endmodule : usb_endpoint_config_regs

// [shared/usb_cfg_pkg.sv]
package usb_cfg_pkg;
   localparam int          data_width       = 32;
   localparam int          addr_width       = 8;
   localparam int          endpoint_count   = 16;
   // byte addresses of the registers
   localparam logic [7:0]  ptr_low_off      = 8'h00;
   localparam logic [7:0]  ptr_mid_off      = 8'h04;
   localparam logic [7:0]  ptr_top_off      = 8'h08;
   localparam logic [7:0]  module_cfg_off   = 8'h0c;
   localparam logic [7:0]  power_ctrl_off   = 8'h10;
   localparam logic [7:0]  irq_status_off   = 8'h14;
   localparam logic [7:0]  irq_mask_off     = 8'h18;
   localparam logic [7:0]  state_off        = 8'h1c;
   localparam logic [7:0]  endpoint_base    = 8'h40;
   // module configuration fields
   localparam int          eye_test_bit     = 7;
   localparam int          oe_monitor_bit   = 6;
   localparam int          stop_idle_bit    = 4;
   localparam int          auto_suspend_bit = 0;
   localparam logic [7:0]  module_cfg_mask  = 8'hd1;
   // power control fields
   localparam int          manual_suspend_bit = 1;
   localparam logic [7:0]  power_ctrl_mask  = 8'h02;
   // endpoint control fields
   localparam int          low_speed_bit    = 7;
   localparam int          retry_dis_bit    = 6;
   localparam int          ctrl_dis_bit     = 4;
   localparam int          rx_en_bit        = 3;
   localparam int          tx_en_bit        = 2;
   localparam int          stall_bit        = 1;
   localparam int          handshake_bit    = 0;
   localparam logic [7:0]  endpoint_mask    = 8'hdf;
   localparam logic [7:0]  ptr_low_mask     = 8'hfe;
   // interrupt events
   localparam int          irq_stall_bit    = 0;
   localparam int          irq_suspend_bit  = 1;
   localparam logic [7:0]  irq_mask_bits    = 8'h03;
   localparam logic [7:0]  reg_reset        = 8'h00;
   localparam logic [1:0]  resp_okay        = 2'b00;
   localparam logic [1:0]  resp_slverr      = 2'b10;
endpackage : usb_cfg_pkg

// [design/usb_cfg_axi_slave.sv]
`timescale 1ns/1ps
module usb_cfg_axi_slave
   import usb_cfg_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic [addr_width-1:0] s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [addr_width-1:0] s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   output logic                       wr_strobe,
   output logic [addr_width-1:0]      wr_addr,
   output logic [7:0]                 wr_byte,
   input  wire logic                  wr_ok,
   output logic                       rd_strobe,
   output logic [addr_width-1:0]      rd_addr,
   input  wire logic [7:0]            rd_byte,
   input  wire logic                  rd_ok
);
   logic                  aw_held, w_held, next_aw_held, next_w_held;
   logic [addr_width-1:0] aw_addr, next_aw_addr;
   logic [7:0]            w_byte, next_w_byte;
   logic                  w_lane0, next_w_lane0;
   logic                  next_bvalid, next_rvalid;
   logic [1:0]            next_bresp, next_rresp;
   logic [31:0]           next_rdata;
   logic                  fire_wr;

   assign fire_wr       = aw_held && w_held && !s_axi_bvalid;
   assign wr_strobe     = fire_wr && w_lane0;
   assign wr_addr       = aw_addr;
   assign wr_byte       = w_byte;
   assign rd_strobe     = s_axi_arvalid && s_axi_arready;
   assign rd_addr       = s_axi_araddr;

   always_comb
   begin
      next_aw_held = aw_held;
      next_w_held  = w_held;
      next_aw_addr = aw_addr;
      next_w_byte  = w_byte;
      next_w_lane0 = w_lane0;
      next_bvalid  = s_axi_bvalid;
      next_bresp   = s_axi_bresp;
      next_rvalid  = s_axi_rvalid;
      next_rresp   = s_axi_rresp;
      next_rdata   = s_axi_rdata;
      if (s_axi_awvalid && s_axi_awready)
      begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         next_w_held  = 1'b1;
         next_w_byte  = s_axi_wdata[7:0];
         next_w_lane0 = s_axi_wstrb[0];
      end
      if (fire_wr)
      begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = wr_ok ? resp_okay : resp_slverr;
      end
      else if (s_axi_bvalid && s_axi_bready)
         next_bvalid = 1'b0;
      if (rd_strobe)
      begin
         next_rvalid = 1'b1;
         next_rresp  = rd_ok ? resp_okay : resp_slverr;
         next_rdata  = {24'h000000, rd_byte};
      end
      else if (s_axi_rvalid && s_axi_rready)
         next_rvalid = 1'b0;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= '0;
         w_byte       <= 8'h00;
         w_lane0      <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= 2'b00;
         s_axi_rdata  <= 32'h00000000;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_arready <= 1'b1;
      end
      else
      begin
         aw_held      <= next_aw_held;
         w_held       <= next_w_held;
         aw_addr      <= next_aw_addr;
         w_byte       <= next_w_byte;
         w_lane0      <= next_w_lane0;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp  <= next_bresp;
         s_axi_rvalid <= next_rvalid;
         s_axi_rresp  <= next_rresp;
         s_axi_rdata  <= next_rdata;
         // readies follow the next slot state: awready/wready drop while held or while next_bvalid is set, arready while next_rvalid is set
         s_axi_awready <= !next_aw_held && !next_bvalid;
         s_axi_wready  <= !next_w_held && !next_bvalid;
         s_axi_arready <= !next_rvalid;
      end
   end
endmodule : usb_cfg_axi_slave

// [design/usb_pin_sync.sv]
`timescale 1ns/1ps
module usb_pin_sync #(
   parameter int width = 1
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [width-1:0] pin,
   output logic [width-1:0]      level
);
   logic [width-1:0] first_stage;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         first_stage <= '0;
         level       <= '0;
      end
      else
      begin
         first_stage <= pin;
         level       <= first_stage;
      end
   end
endmodule : usb_pin_sync

// [verif/usb_peer_model.sv]
`timescale 1ns/1ps
module usb_peer_model (
   input  wire logic       clk,
   input  wire logic [3:0] ep_req,
   input  wire logic       stall_req,
   output logic [3:0]      token_endpoint,
   output logic            stall_event
);
   always_ff @(posedge clk)
   begin
      token_endpoint <= ep_req;
      stall_event    <= stall_req;
   end
endmodule : usb_peer_model

// [verif/tb_usb_endpoint_config_regs.sv]
`timescale 1ns/1ps
module tb_usb_endpoint_config_regs
   import usb_cfg_pkg::*;
();
   logic clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, host_mode;
   logic chip_idle, chip_sleep, line_driving, token_setup, stall_event, eye_pattern_test_en;
   logic drive_enable_monitor, module_run, module_suspended, clk48_enable, low_speed_direct;
   logic use_preamble, hw_nak_retry, token_rx_allowed, token_tx_allowed, token_setup_allowed;
   logic token_handshake, irq, stall_req, ta, tw, tr, dn;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, epv [16];
   logic [31:0] s_axi_wdata, s_axi_rdata, table_base, q, d, pv;
   logic [3:0]  s_axi_wstrb, token_endpoint, ep_req;
   logic [1:0]  s_axi_bresp, s_axi_rresp, r;
   integer      seed = 32'h7b84, errors = 0, tests_run = 0, i;
   usb_endpoint_config_regs DUT (.*);
   usb_peer_model peer (.clk(clk), .ep_req(ep_req), .stall_req(stall_req),
      .token_endpoint(token_endpoint), .stall_event(stall_event));
   initial forever #50 clk = !clk;
   initial #3_000_000 begin errors++; complete_run(); end
   function automatic logic [31:0] base_of(logic [31:0] p);
      return {p[23:16], p[15:8], p[7:1], 9'h0};
   endfunction : base_of
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin $display("BAD %s expected %h seen %h", n, e, g); errors++; end
   endtask : chk
   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : complete_run
   // address and data channels are released at the edge where their ready was seen high, bready/rready where the response valid was seen
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {w, w, w, !w, !w};
      s_axi_awaddr <= a; s_axi_araddr <= a; s_axi_wdata <= wd; s_axi_wstrb <= 4'hf; dn = 1'h0;
      while (!dn)
      begin
         @(negedge clk);
         {ta, tw, tr, dn, r, q} = {s_axi_awready, s_axi_wready, s_axi_arready,
            w ? {s_axi_bvalid, s_axi_bresp} : {s_axi_rvalid, s_axi_rresp}, s_axi_rdata};
         @(posedge clk);
         s_axi_awvalid <= s_axi_awvalid & !ta;
         s_axi_wvalid <= s_axi_wvalid & !tw;
         s_axi_arvalid <= s_axi_arvalid & !tr;
         {s_axi_bready, s_axi_rready} <= {s_axi_bready, s_axi_rready} & {2{!dn}};
      end
   endtask : bus
   initial
   begin
      {rst, clk, host_mode, chip_idle, chip_sleep, line_driving, token_setup, stall_req} = 8'h80;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, ep_req} = 9'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
      repeat (5) @(posedge clk);
      rst <= 1'h0;
      for (i = 0; i < 3; i++) begin d = $random(seed); pv[8*i+:8] = d[7:0]; bus(1, 8'(4*i), d); end
      chk("table base", base_of(pv), table_base);
      bus(0, ptr_low_off, 0);
      chk("low pointer", {24'h0, pv[7:0] & ptr_low_mask}, q);
      d = $random(seed);
      bus(1, module_cfg_off, d);
      chk("eye test", 32'(d[eye_test_bit]), 32'(eye_pattern_test_en));
      $display("pointer test done");
      for (i = 0; i < 16; i++)
      begin
         d = $random(seed);
         epv[i] = d[7:0] & endpoint_mask;
         bus(1, endpoint_base + 8'(4*i), d);
      end
      for (i = 0; i < 16; i++)
      begin
         bus(0, endpoint_base + 8'(4*i), 0);
         chk("endpoint", {24'h0, epv[i]}, q);
         ep_req <= 4'(i);
         repeat (3) @(posedge clk);
         chk("receive", 32'(epv[i][rx_en_bit]), 32'(token_rx_allowed));
         chk("transmit", 32'(epv[i][tx_en_bit]), 32'(token_tx_allowed));
      end
      $display("endpoint test done");
      bus(1, irq_mask_off, 1);
      bus(1, endpoint_base + 8'h14, 32'h0c);
      ep_req <= 4'h5; stall_req <= 1'h1;
      @(posedge clk) stall_req <= 1'h0;
      bus(0, endpoint_base + 8'h14, 0);
      chk("stall flag", 32'h0e, q);
      chk("irq raised", 32'h1, 32'(irq));
      bus(1, irq_mask_off, 0);
      @(posedge clk);
      chk("irq masked", 32'h0, 32'(irq));
      bus(1, irq_status_off, 1); bus(1, irq_mask_off, 1); bus(0, state_off, 0);
      chk("irq cleared", 32'h0, 32'(irq));
      bus(0, 8'hfc, 0);
      chk("unmapped", {30'h0, resp_slverr}, {30'h0, r});
      $display("interrupt test done");
      {host_mode, token_setup, line_driving, chip_sleep} <= 4'hf; ep_req <= 4'h0;
      bus(1, module_cfg_off, 32'h51);
      repeat (2) @(posedge clk);
      chk("suspended", 32'h1, 32'(module_suspended));
      chk("clock gate", 32'h0, 32'(clk48_enable));
      chk("oe monitor", 32'h1, 32'(drive_enable_monitor));
      chk("low speed", 32'(epv[0][low_speed_bit]), 32'(low_speed_direct));
      chk("preamble", 32'(!epv[0][low_speed_bit]), 32'(use_preamble));
      chk("nak retry", 32'(!epv[0][retry_dis_bit]), 32'(hw_nak_retry));
      chk("setup", 32'(epv[0][rx_en_bit] & epv[0][tx_en_bit] & !epv[0][ctrl_dis_bit]),
         32'(token_setup_allowed));
      chk("handshake", 32'(epv[0][handshake_bit]), 32'(token_handshake));
      {chip_sleep, chip_idle} <= 2'b01;
      repeat (6) @(posedge clk);
      bus(0, state_off, 0);
      chk("idle state", 32'h2, q);
      chk("idle halt", 32'h0, 32'(module_run));
      bus(1, power_ctrl_off, 2);
      repeat (2) @(posedge clk);
      chk("manual suspend", 32'h1, 32'(module_suspended));
      bus(1, power_ctrl_off, 0); chip_idle <= 1'h0;
      repeat (6) @(posedge clk);
      chk("resumed", 32'h1, 32'(module_run));
      $display("power test done");
      complete_run();
   end
endmodule : tb_usb_endpoint_config_regs
